// *** rtl/thc_defines.svh ***
// Purpose: offsets, field positions, codes, reset values and timing counts
// Assumes: 10 MHz system clock, registers on 32-bit word offsets
// Notes:   definitions only
`ifndef THC_DEFINES_SVH
`define THC_DEFINES_SVH
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define THC_CLK_PERIOD_NS 100
`define THC_TO_MIN_DELAY_NS 600
`define THC_TO_MIN_CYC ((`THC_TO_MIN_DELAY_NS + `THC_CLK_PERIOD_NS - 1) / `THC_CLK_PERIOD_NS)
`define THC_NOTRIG_MS 1000
`define THC_NOTRIG_CYC (`THC_NOTRIG_MS * 1000000 / `THC_CLK_PERIOD_NS)
`define THC_FREE_RUN_NS 10000
`define THC_FREE_CYC (`THC_FREE_RUN_NS / `THC_CLK_PERIOD_NS)
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define THC_R_CTRL 8'h00
`define THC_R_CMD 8'h04
`define THC_R_HOLD_TIME 8'h08
`define THC_R_HOLD_EVENTS 8'h0C
`define THC_R_HOLD_MIN 8'h10
`define THC_R_HOLD_MAX 8'h14
`define THC_R_AUTO_SCALE 8'h18
`define THC_R_HSCALE 8'h1C
`define THC_R_AUTO_TIME 8'h20
`define THC_R_AUTO_IVL 8'h24
`define THC_R_LEVEL 8'h28
`define THC_R_HYST_ABS 8'h2C
`define THC_R_HYST_REL 8'h30
`define THC_R_VDIV 8'h34
`define THC_R_BAND 8'h38
`define THC_R_LOW_BAND_CUT 8'h3C
`define THC_R_HIGH_BAND_CUT 8'h40
`define THC_R_TO_DELAY 8'h44
`define THC_R_TO_LEN 8'h48
`define THC_R_STATUS 8'h4C
`define THC_R_ELAPSED 8'h50
// ----------------------------------------------------------------------
// control fields and codes
// ----------------------------------------------------------------------
`define THC_F_TMODE 1:0
`define THC_F_HMODE 4:2
`define THC_F_SRC 6:5
`define THC_F_SEQ 7
`define THC_F_SLOPE 8
`define THC_F_HMAN 9
`define THC_F_HREL 10
`define THC_F_FMODE 12:11
`define THC_F_TO_EN 13
`define THC_F_TO_SRC 15:14
`define THC_F_TO_POL 16
`define THC_F_FORCE 0
`define THC_TM_AUTO 2'h0
`define THC_TM_NORMAL 2'h1
`define THC_TM_FREE 2'h2
`define THC_HM_OFF 3'h0
`define THC_HM_TIME 3'h1
`define THC_HM_EVENTS 3'h2
`define THC_HM_RANDOM 3'h3
`define THC_HM_AUTO 3'h4
`define THC_SRC_CHAN 2'h0
`define THC_SRC_LINE 2'h1
`define THC_SRC_EXT 2'h2
`define THC_SRC_SERIAL 2'h3
`define THC_TOS_TRIG 2'h0
`define THC_TOS_WAIT 2'h1
`define THC_TOS_POST 2'h2
`define THC_FM_OFF 2'h0
`define THC_FM_LOW_CUT 2'h1
`define THC_FM_HIGH_CUT 2'h2
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define THC_HYST_AUTO 16'h0010
`define THC_LFSR_SEED 32'h0000_0001
`define THC_TO_LEN_RST 32'h0000_0001
`endif

// *** rtl/thc_pkg.sv ***
// Purpose: types of the trigger holdoff control block
// Assumes: thc_defines.svh carries all numbers
// Notes:   state of the top module is one packed struct
package thc_pkg;
  typedef enum logic [1:0] {
    THC_TO_IDLE = 2'b00,
    THC_TO_DELAY = 2'b01,
    THC_TO_PULSE = 2'b11
  } thc_to_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } thc_bus_req_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [15:0] cut;
  } thc_filt_t;

  typedef struct packed {
    logic [1:0] tmode;
    logic [2:0] hmode;
    logic [1:0] src;
    logic seq, slope, hman, hrel;
    logic [1:0] fmode;
    logic to_en;
    logic [1:0] to_src;
    logic to_pol;
    logic [31:0] hold_time, hold_min, hold_max, auto_ivl, to_delay, to_len;
    logic [15:0] hold_ev, scale, hscale, level, habs, hrel_v, vdiv, lf_cut, hf_cut;
    logic line_s1, line_s2, line_q, schmitt, wait_q;
    logic [1:0] tmode_q;
    logic [31:0] hold_cnt, auto_cnt, elapsed, lfsr, to_cnt;
    logic [15:0] ev_cnt, free_cnt;
    thc_to_state_t to_st;
    logic acq_start, act_fire, no_trig, trig_out;
    logic [15:0] band;
    thc_filt_t filt;
    logic [31:0] rdata;
  } thc_state_t;
endpackage : thc_pkg

// *** rtl/thc_top.sv ***
// Purpose: trigger acceptance, holdoff, hysteresis and trigger-out pulse
// Assumes: SAMPLE, EXT_EVT, WAIT_TRIG, POST_DONE on CLK; LINE_IN is a pin
// Notes:   CE low freezes all state, bus accesses included
`include "thc_defines.svh"
module thc_top #(
  parameter logic [31:0] NOTRIG_CYC = 32'(`THC_NOTRIG_CYC)
) (
  // clock, reset, enable
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CE,
  // register port
  input wire thc_pkg::thc_bus_req_t BUS_REQ,
  output logic [31:0] RDATA,
  // trigger inputs
  input wire logic [15:0] SAMPLE,
  input wire logic LINE_IN,
  input wire logic EXT_EVT,
  input wire logic WAIT_TRIG,
  input wire logic POST_DONE,
  // acquisition side
  output logic ACQ_START,
  output logic ACT_FIRE,
  output logic NO_TRIG,
  // trigger-out connector
  output logic TRIG_OUT,
  // front end settings
  output logic [15:0] APPLIED_NOISE_BAND,
  output thc_pkg::thc_filt_t FILT_CFG
);
  localparam logic [15:0] FREE_CYC = 16'(`THC_FREE_CYC);
  localparam logic [31:0] TO_MIN_CYC = 32'(`THC_TO_MIN_CYC);

  thc_pkg::thc_state_t s;
  thc_pkg::thc_state_t n;
  logic [15:0] band_w, half_w;
  logic [31:0] auto_time_w, dly_w, len_w;
  logic above_w, below_w, inside_w, line_edge_w, ch_edge_w, raw_w;
  logic hold_on_w, blocked_w, force_w, real_w, auto_gen_w, free_fire_w;
  logic start_w, launch_w;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] sat_inc(input logic [31:0] x);
    sat_inc = (x == 32'hFFFF_FFFF) ? x : x + 32'h1;
  endfunction

  // scaling by multiply avoids a divider; result stays in lo..hi, and is lo when hi <= lo
  function automatic logic [31:0] rand_pick(input logic [31:0] lo, input logic [31:0] hi,
                                            input logic [15:0] r);
    logic [32:0] span;
    logic [48:0] prod;
    span = (hi > lo) ? ({1'b0, hi} - {1'b0, lo} + 33'h1) : 33'h1;
    prod = {16'h0, span} * {33'h0, r};
    rand_pick = lo + prod[47:16];
  endfunction

  // relative band in 1/256 division times codes per division
  function automatic logic [15:0] rel_band(input logic [15:0] rel, input logic [15:0] vdiv);
    logic [31:0] p;
    p = {16'h0, rel} * {16'h0, vdiv};
    rel_band = p[23:8];
  endfunction

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    n = s;
    n.acq_start = 1'b0;
    n.act_fire = 1'b0;
    n.rdata = 32'h0;
    // mains pin passes two flops before the edge detector
    n.line_s1 = LINE_IN;
    n.line_s2 = s.line_s1;
    n.line_q = s.line_s2;
    n.wait_q = WAIT_TRIG;
    n.tmode_q = s.tmode;
    n.lfsr = {s.lfsr[30:0], s.lfsr[31] ^ s.lfsr[21] ^ s.lfsr[1] ^ s.lfsr[0]};

    if (!s.hman)
      band_w = `THC_HYST_AUTO;
    else if (s.hrel)
      band_w = rel_band(s.hrel_v, s.vdiv);
    else
      band_w = s.habs;
    half_w = {1'b0, band_w[15:1]};
    n.band = band_w;

    above_w = {1'b0, SAMPLE} > ({1'b0, s.level} + {1'b0, half_w});
    below_w = ({1'b0, SAMPLE} + {1'b0, half_w}) < {1'b0, s.level};
    inside_w = !above_w && !below_w;
    if (above_w)
      n.schmitt = 1'b1;
    else if (below_w)
      n.schmitt = 1'b0;
    ch_edge_w = s.slope ? (s.schmitt && !n.schmitt) : (!s.schmitt && n.schmitt);

    line_edge_w = s.slope ? (!s.line_s2 && s.line_q) : (s.line_s2 && !s.line_q);

    case (s.src)
      `THC_SRC_CHAN: raw_w = ch_edge_w;
      `THC_SRC_LINE: raw_w = line_edge_w;
      default: raw_w = EXT_EVT;
    endcase

    hold_on_w = (s.src == `THC_SRC_CHAN || s.src == `THC_SRC_LINE) && !s.seq;
    if (s.hmode == `THC_HM_EVENTS)
      blocked_w = hold_on_w && (s.ev_cnt != 16'h0);
    else if (s.hmode == `THC_HM_OFF)
      blocked_w = 1'b0;
    else
      blocked_w = hold_on_w && (s.hold_cnt != 32'h0);

    auto_time_w = {16'h0, s.scale} * {16'h0, s.hscale};

    force_w = BUS_REQ.we && (BUS_REQ.addr == `THC_R_CMD) && BUS_REQ.wdata[`THC_F_FORCE];
    real_w = raw_w && (s.tmode != `THC_TM_FREE) && !blocked_w;
    auto_gen_w = (s.tmode == `THC_TM_AUTO) && (s.auto_cnt >= s.auto_ivl) && !real_w;
    free_fire_w = (s.tmode == `THC_TM_FREE)
                  && ((s.free_cnt >= FREE_CYC - 16'h1) || (s.tmode_q != `THC_TM_FREE));
    start_w = force_w || real_w || auto_gen_w || free_fire_w;

    if (raw_w && hold_on_w && s.hmode == `THC_HM_EVENTS && s.ev_cnt != 16'h0
        && s.tmode != `THC_TM_FREE)
      n.ev_cnt = s.ev_cnt - 16'h1;

    n.acq_start = start_w;
    n.act_fire = start_w;
    n.auto_cnt = start_w ? 32'h0 : sat_inc(s.auto_cnt);
    n.free_cnt = start_w ? 16'h0 : ((s.free_cnt == 16'hFFFF) ? s.free_cnt : s.free_cnt + 16'h1);

    n.elapsed = start_w ? 32'h0 : sat_inc(s.elapsed);
    n.no_trig = (s.tmode == `THC_TM_NORMAL) && (s.elapsed >= NOTRIG_CYC) && !start_w;

    if (start_w)
    begin
      n.ev_cnt = 16'h0;
      case (s.hmode)
        `THC_HM_TIME: n.hold_cnt = s.hold_time;
        `THC_HM_RANDOM: n.hold_cnt = rand_pick(s.hold_min, s.hold_max, s.lfsr[15:0]);
        `THC_HM_AUTO: n.hold_cnt = auto_time_w;
        `THC_HM_EVENTS:
        begin
          n.hold_cnt = 32'h0;
          n.ev_cnt = s.hold_ev;
        end
        default: n.hold_cnt = 32'h0;
      endcase
    end
    else if (s.hold_cnt != 32'h0)
      n.hold_cnt = s.hold_cnt - 32'h1;

    n.filt.mode = s.fmode;
    case (s.fmode)
      `THC_FM_LOW_CUT: n.filt.cut = s.lf_cut;
      `THC_FM_HIGH_CUT: n.filt.cut = s.hf_cut;
      default: n.filt.cut = 16'h0;
    endcase

    case (s.to_src)
      `THC_TOS_WAIT: launch_w = WAIT_TRIG && !s.wait_q;
      `THC_TOS_POST: launch_w = POST_DONE;
      default: launch_w = start_w;
    endcase
    dly_w = (s.to_delay < TO_MIN_CYC) ? TO_MIN_CYC : s.to_delay;
    len_w = (s.to_len == 32'h0) ? 32'h1 : s.to_len;

    unique case (s.to_st)
      thc_pkg::THC_TO_IDLE:
      begin
        if (s.to_en && launch_w)
        begin
          n.to_st = thc_pkg::THC_TO_DELAY;
          n.to_cnt = dly_w;
        end
      end
      thc_pkg::THC_TO_DELAY:
      begin
        if (s.to_cnt <= 32'h1)
        begin
          n.to_st = thc_pkg::THC_TO_PULSE;
          n.to_cnt = len_w;
        end
        else
          n.to_cnt = s.to_cnt - 32'h1;
      end
      thc_pkg::THC_TO_PULSE:
      begin
        if (s.to_cnt <= 32'h1)
          n.to_st = thc_pkg::THC_TO_IDLE;
        else
          n.to_cnt = s.to_cnt - 32'h1;
      end
      default: n.to_st = thc_pkg::THC_TO_IDLE;
    endcase
    n.trig_out = s.to_pol ^ (n.to_st == thc_pkg::THC_TO_PULSE);

    // ----------------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------------
    if (BUS_REQ.we)
    begin
      case (BUS_REQ.addr)
        `THC_R_CTRL:
        begin
          n.tmode = BUS_REQ.wdata[`THC_F_TMODE];
          n.hmode = BUS_REQ.wdata[`THC_F_HMODE];
          n.src = BUS_REQ.wdata[`THC_F_SRC];
          n.seq = BUS_REQ.wdata[`THC_F_SEQ];
          n.slope = BUS_REQ.wdata[`THC_F_SLOPE];
          n.hman = BUS_REQ.wdata[`THC_F_HMAN];
          n.hrel = BUS_REQ.wdata[`THC_F_HREL];
          n.fmode = BUS_REQ.wdata[`THC_F_FMODE];
          n.to_en = BUS_REQ.wdata[`THC_F_TO_EN];
          n.to_src = BUS_REQ.wdata[`THC_F_TO_SRC];
          n.to_pol = BUS_REQ.wdata[`THC_F_TO_POL];
        end
        `THC_R_HOLD_TIME: n.hold_time = BUS_REQ.wdata;
        `THC_R_HOLD_EVENTS: n.hold_ev = BUS_REQ.wdata[15:0];
        `THC_R_HOLD_MIN: n.hold_min = BUS_REQ.wdata;
        `THC_R_HOLD_MAX: n.hold_max = BUS_REQ.wdata;
        `THC_R_AUTO_SCALE: n.scale = BUS_REQ.wdata[15:0];
        `THC_R_HSCALE: n.hscale = BUS_REQ.wdata[15:0];
        `THC_R_AUTO_IVL: n.auto_ivl = BUS_REQ.wdata;
        `THC_R_LEVEL: n.level = BUS_REQ.wdata[15:0];
        `THC_R_HYST_ABS: n.habs = BUS_REQ.wdata[15:0];
        `THC_R_HYST_REL: n.hrel_v = BUS_REQ.wdata[15:0];
        `THC_R_VDIV: n.vdiv = BUS_REQ.wdata[15:0];
        `THC_R_LOW_BAND_CUT: n.lf_cut = BUS_REQ.wdata[15:0];
        `THC_R_HIGH_BAND_CUT: n.hf_cut = BUS_REQ.wdata[15:0];
        `THC_R_TO_DELAY: n.to_delay = BUS_REQ.wdata;
        `THC_R_TO_LEN: n.to_len = BUS_REQ.wdata;
        default: ;
      endcase
    end

    // ----------------------------------------------------------------------
    // register reads, data valid in the next cycle only
    // ----------------------------------------------------------------------
    if (BUS_REQ.re)
    begin
      case (BUS_REQ.addr)
        `THC_R_CTRL: n.rdata = {15'h0, s.to_pol, s.to_src, s.to_en, s.fmode, s.hrel, s.hman,
                                s.slope, s.seq, s.src, s.hmode, s.tmode};
        `THC_R_HOLD_TIME: n.rdata = s.hold_time;
        `THC_R_HOLD_EVENTS: n.rdata = {16'h0, s.hold_ev};
        `THC_R_HOLD_MIN: n.rdata = s.hold_min;
        `THC_R_HOLD_MAX: n.rdata = s.hold_max;
        `THC_R_AUTO_SCALE: n.rdata = {16'h0, s.scale};
        `THC_R_HSCALE: n.rdata = {16'h0, s.hscale};
        `THC_R_AUTO_TIME: n.rdata = auto_time_w;
        `THC_R_AUTO_IVL: n.rdata = s.auto_ivl;
        `THC_R_LEVEL: n.rdata = {16'h0, s.level};
        `THC_R_HYST_ABS: n.rdata = {16'h0, s.habs};
        `THC_R_HYST_REL: n.rdata = {16'h0, s.hrel_v};
        `THC_R_VDIV: n.rdata = {16'h0, s.vdiv};
        `THC_R_BAND: n.rdata = {16'h0, band_w};
        `THC_R_LOW_BAND_CUT: n.rdata = {16'h0, s.lf_cut};
        `THC_R_HIGH_BAND_CUT: n.rdata = {16'h0, s.hf_cut};
        `THC_R_TO_DELAY: n.rdata = s.to_delay;
        `THC_R_TO_LEN: n.rdata = s.to_len;
        `THC_R_STATUS: n.rdata = {29'h0, s.to_st != thc_pkg::THC_TO_IDLE, blocked_w, s.no_trig};
        `THC_R_ELAPSED: n.rdata = s.elapsed;
        default: n.rdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      s <= '0;
      s.lfsr <= `THC_LFSR_SEED;
      s.to_delay <= TO_MIN_CYC;
      s.to_len <= `THC_TO_LEN_RST;
      s.band <= `THC_HYST_AUTO;
    end
    else if (CE)
      s <= n;
  end

  assign RDATA = s.rdata;
  assign ACQ_START = s.acq_start;
  assign ACT_FIRE = s.act_fire;
  assign NO_TRIG = s.no_trig;
  assign TRIG_OUT = s.trig_out;
  assign APPLIED_NOISE_BAND = s.band;
  assign FILT_CFG = s.filt;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  property p_force;
    @(posedge CLK) disable iff (!RESET_N || !CE) force_w |=> ACQ_START;
  endproperty
  a_force: assert property (p_force) else $error("force gave no acquisition");

  property p_line;
    @(posedge CLK) disable iff (!RESET_N || !CE)
      (s.src == `THC_SRC_LINE && s.tmode == `THC_TM_NORMAL && !blocked_w && line_edge_w)
      |=> ACQ_START;
  endproperty
  a_line: assert property (p_line) else $error("mains edge not accepted");

  property p_auto;
    @(posedge CLK) disable iff (!RESET_N || !CE)
      (s.tmode == `THC_TM_AUTO && s.auto_cnt >= s.auto_ivl) |=> ACQ_START;
  endproperty
  a_auto: assert property (p_auto) else $error("auto trigger missing");

  property p_free;
    @(posedge CLK) disable iff (!RESET_N || !CE)
      (s.tmode == `THC_TM_FREE && s.tmode_q == `THC_TM_FREE && !force_w
       && s.free_cnt < FREE_CYC - 16'h1) |=> !ACQ_START;
  endproperty
  a_free: assert property (p_free) else $error("free run took a real trigger");

  property p_notrig;
    @(posedge CLK) disable iff (!RESET_N || !CE)
      NO_TRIG |-> (s.tmode_q == `THC_TM_NORMAL && $past(s.elapsed) >= NOTRIG_CYC);
  endproperty
  a_notrig: assert property (p_notrig) else $error("no-trigger flag early");

  property p_hold_time;
    @(posedge CLK) disable iff (!RESET_N || !CE)
      (s.hmode == `THC_HM_TIME && hold_on_w && s.hold_cnt != 32'h0 && !force_w
       && s.tmode == `THC_TM_NORMAL) |=> !ACQ_START;
  endproperty
  a_hold_time: assert property (p_hold_time) else $error("trigger during holdoff");

  property p_hold_ev;
    @(posedge CLK) disable iff (!RESET_N || !CE)
      (s.hmode == `THC_HM_EVENTS && hold_on_w && s.ev_cnt != 16'h0 && raw_w && !force_w
       && s.tmode == `THC_TM_NORMAL) |=> (!ACQ_START && s.ev_cnt == $past(s.ev_cnt) - 16'h1);
  endproperty
  a_hold_ev: assert property (p_hold_ev) else $error("event not skipped");

  property p_ext;
    @(posedge CLK) disable iff (!RESET_N || !CE)
      (s.src == `THC_SRC_EXT && raw_w && s.tmode == `THC_TM_NORMAL) |=> ACQ_START;
  endproperty
  a_ext: assert property (p_ext) else $error("holdoff applied to external");

  property p_band_auto;
    @(posedge CLK) disable iff (!RESET_N || !CE) !s.hman |=> APPLIED_NOISE_BAND == `THC_HYST_AUTO;
  endproperty
  a_band_auto: assert property (p_band_auto) else $error("auto band wrong");

  property p_band_hold;
    @(posedge CLK) disable iff (!RESET_N || !CE)
      (s.hman && inside_w) |=> s.schmitt == $past(s.schmitt);
  endproperty
  a_band_hold: assert property (p_band_hold) else $error("crossing inside band");

  property p_to_delay;
    @(posedge CLK) disable iff (!RESET_N || !CE)
      (s.to_st == thc_pkg::THC_TO_IDLE && s.to_en && launch_w) |=> (TRIG_OUT == s.to_pol)[*6];
  endproperty
  a_to_delay: assert property (p_to_delay) else $error("trigger-out too early");

  property p_to_len;
    @(posedge CLK) disable iff (!RESET_N || !CE)
      (s.to_st == thc_pkg::THC_TO_DELAY && s.to_cnt <= 32'h1 && len_w == 32'h3)
      |=> (TRIG_OUT != s.to_pol)[*3] ##1 (TRIG_OUT == s.to_pol);
  endproperty
  a_to_len: assert property (p_to_len) else $error("trigger-out length wrong");

  property p_to_en;
    @(posedge CLK) disable iff (!RESET_N || !CE)
      (s.to_st == thc_pkg::THC_TO_IDLE && !s.to_en) |=> s.to_st == thc_pkg::THC_TO_IDLE;
  endproperty
  a_to_en: assert property (p_to_en) else $error("trigger-out while disabled");
endmodule // thc_top

// *** verification/thc_far_model.sv ***
// Purpose: acquisition engine and trigger-out listener
// Assumes: WAIT_TRIG level, POST_DONE one-cycle pulse
// Notes:   delay counts cycles from the launch mark seen here
module thc_far_model (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET_N,
  // bench requests
  input wire logic wait_req,
  input wire logic post_req,
  input wire logic pol,
  // design side
  input wire logic ACQ_START,
  input wire logic TRIG_OUT,
  output logic WAIT_TRIG,
  output logic POST_DONE,
  // measured pulse
  output logic [7:0] dly,
  output logic [7:0] len,
  output logic [7:0] pulses
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt;
  logic act;
  logic act_q;
  logic wt_q;
  assign act = (TRIG_OUT !== pol);
  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      {WAIT_TRIG, POST_DONE, wt_q, act_q, cnt, dly, len, pulses} <= '0;
    end
    else
    begin
      WAIT_TRIG <= wait_req;
      POST_DONE <= post_req;
      wt_q <= WAIT_TRIG;
      act_q <= act;
      cnt <= (ACQ_START || (WAIT_TRIG && !wt_q) || POST_DONE) ? 8'h01 : cnt + 8'h01;
      if (act && !act_q)
      begin
        dly <= cnt;
        pulses <= pulses + 8'h01;
      end
      if (act)
        len <= act_q ? len + 8'h01 : 8'h01;
    end
  end
endmodule // thc_far_model

// *** verification/thc_tb_top.sv ***
// Purpose: self-checking bench of the trigger holdoff block
// Assumes: CE held high, channel sample idle until the hysteresis tests
// Notes:   starts counted on ACQ_START pulses
`include "thc_defines.svh"
module thc_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NTRIG = 50;
  logic CLK = 0, RESET_N = 0, LINE_IN = 0, EXT_EVT = 0, WAIT_TRIG, POST_DONE;
  logic wait_req = 0, post_req = 0, pol = 0;
  thc_pkg::thc_bus_req_t bus = '0;
  logic [31:0] RDATA;
  logic ACQ_START, ACT_FIRE, NO_TRIG, TRIG_OUT;
  logic [15:0] band;
  logic [15:0] sample = 16'h0000;
  thc_pkg::thc_filt_t filt;
  logic [7:0] dly, len, pulses;
  int mismatches = 0, compares = 0, starts = 0, s0;
  thc_top #(.NOTRIG_CYC(32'(NTRIG))) uut (.CLK(CLK), .RESET_N(RESET_N), .CE(1'b1),
    .BUS_REQ(bus), .RDATA(RDATA), .SAMPLE(sample), .LINE_IN(LINE_IN), .EXT_EVT(EXT_EVT),
    .WAIT_TRIG(WAIT_TRIG), .POST_DONE(POST_DONE), .ACQ_START(ACQ_START), .ACT_FIRE(ACT_FIRE),
    .NO_TRIG(NO_TRIG), .TRIG_OUT(TRIG_OUT), .APPLIED_NOISE_BAND(band), .FILT_CFG(filt));
  thc_far_model far (.CLK(CLK), .RESET_N(RESET_N), .wait_req(wait_req), .post_req(post_req),
    .pol(pol), .ACQ_START(ACQ_START), .TRIG_OUT(TRIG_OUT), .WAIT_TRIG(WAIT_TRIG),
    .POST_DONE(POST_DONE), .dly(dly), .len(len), .pulses(pulses));
  always #50 CLK = ~CLK;
  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] e, input logic [31:0] a);
    compares++;
    if (a !== e)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, a, e);
    end
  endtask
  // edges then settle, so later samples never race the update
  task tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge CLK) bus <= '0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge CLK) bus <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge CLK) bus <= '0;
    #1 chk(e, RDATA);
  endtask
  task samp(input logic [15:0] v);
    @(posedge CLK) sample <= v;
    tick(4);
  endtask
  task line(input int n);
    repeat (n)
    begin
      @(posedge CLK) LINE_IN <= ~LINE_IN;
      tick(6);
    end
  endtask
  function logic [31:0] cw(logic [1:0] tm, logic [2:0] hm, logic [1:0] sr, logic sl,
    logic [1:0] fm, logic en, logic [1:0] ts, logic p);
    return {15'h0, p, ts, en, fm, 2'b00, sl, 1'b0, sr, hm, tm};
  endfunction
  // kind 0 force, 1 waiting edge, 2 post-trigger end
  task to_case(input logic [31:0] c, input int kind, input logic [7:0] e);
    wr(`THC_R_CTRL, c);
    tick(3);
    pol = c[16];
    chk(c[16], TRIG_OUT);
    if (kind == 0)
      wr(`THC_R_CMD, 32'h1);
    @(posedge CLK) wait_req <= (kind == 1);
    post_req <= (kind == 2);
    @(posedge CLK) post_req <= 1'b0;
    tick(20);
    wait_req <= 1'b0;
    chk(e, dly);
    chk(8'h03, len);
  endtask
  // sampled mid-cycle so the count never races the launching edge
  always @(negedge CLK)
  begin
    if (ACQ_START === 1'b1)
      starts++;
    if (RESET_N === 1'b1)
      chk(ACQ_START, ACT_FIRE);
  end
  initial
  begin
    #3000000;
    mismatches++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    report_and_stop;
  end
  initial
  begin
    tick(3);
    RESET_N = 1;
    chk(16'h0010, band);
    chk(0, filt);
    rd(`THC_R_BAND, 32'h10);
    wr(`THC_R_CTRL, cw(1, 0, 2, 0, 0, 0, 0, 0));
    rd(8'hFC, 0);
    rd(`THC_R_CMD, 0);
    wr(`THC_R_AUTO_SCALE, 3);
    wr(`THC_R_HSCALE, 5);
    rd(`THC_R_AUTO_TIME, 15);
    wr(`THC_R_LOW_BAND_CUT, 16'h1234);
    wr(`THC_R_HIGH_BAND_CUT, 16'h0567);
    wr(`THC_R_CTRL, cw(1, 0, 2, 0, 1, 0, 0, 0));
    tick(2);
    chk({2'h1, 16'h1234}, filt);
    wr(`THC_R_CTRL, cw(1, 0, 2, 0, 2, 0, 0, 0));
    tick(2);
    chk({2'h2, 16'h0567}, filt);
    wr(`THC_R_HOLD_TIME, 40);
    wr(`THC_R_CTRL, cw(1, 1, 1, 0, 0, 0, 0, 0));
    tick(50);
    s0 = starts;
    line(2);
    wr(`THC_R_CMD, 32'h1);
    line(2);
    tick(45);
    line(2);
    chk(s0 + 3, starts);
    wr(`THC_R_HOLD_EVENTS, 2);
    wr(`THC_R_CTRL, cw(1, 2, 1, 0, 0, 0, 0, 0));
    s0 = starts;
    line(8);
    chk(s0 + 2, starts);
    wr(`THC_R_CTRL, cw(1, 0, 1, 1, 0, 0, 0, 0));
    s0 = starts;
    line(2);
    chk(s0 + 1, starts);
    wr(`THC_R_CTRL, cw(1, 1, 2, 0, 0, 0, 0, 0));
    s0 = starts;
    repeat (2)
    begin
      @(posedge CLK) EXT_EVT <= 1'b1;
      @(posedge CLK) EXT_EVT <= 1'b0;
      tick(2);
    end
    chk(s0 + 2, starts);
    s0 = starts;
    wr(`THC_R_CTRL, cw(2, 0, 2, 0, 0, 0, 0, 0));
    @(posedge CLK) EXT_EVT <= 1'b1;
    @(posedge CLK) EXT_EVT <= 1'b0;
    tick(140);
    wr(`THC_R_CTRL, cw(1, 0, 2, 0, 0, 0, 0, 0));
    chk(s0 + 2, starts);
    tick(NTRIG + 10);
    chk(1, NO_TRIG);
    rd(`THC_R_STATUS, 1);
    wr(`THC_R_CMD, 32'h1);
    tick(2);
    chk(0, NO_TRIG);
    wr(`THC_R_TO_DELAY, 2);
    wr(`THC_R_TO_LEN, 3);
    to_case(cw(1, 0, 2, 0, 0, 1, 0, 0), 0, 8'h06);
    to_case(cw(1, 0, 2, 0, 0, 1, 0, 1), 0, 8'h06);
    to_case(cw(1, 0, 2, 0, 0, 1, 1, 0), 1, 8'h07);
    to_case(cw(1, 0, 2, 0, 0, 1, 2, 0), 2, 8'h07);
    wr(`THC_R_LEVEL, 16'h0100);
    wr(`THC_R_HYST_ABS, 16'h0040);
    wr(`THC_R_CTRL, cw(1, 0, 0, 0, 0, 0, 0, 0) | 32'h200);
    rd(`THC_R_BAND, 32'h40);
    s0 = starts;
    samp(16'h0110);
    samp(16'h0130);
    samp(16'h00F0);
    samp(16'h00D0);
    samp(16'h0130);
    chk(s0 + 2, starts);
    wr(`THC_R_HYST_REL, 16'h0080);
    wr(`THC_R_VDIV, 16'h0080);
    wr(`THC_R_CTRL, cw(1, 0, 0, 0, 0, 0, 0, 0) | 32'h600);
    rd(`THC_R_BAND, 32'h40);
    chk(16'h0040, band);
    s0 = starts;
    samp(16'h00D0);
    samp(16'h0110);
    samp(16'h0130);
    chk(s0 + 1, starts);
    s0 = pulses;
    wr(`THC_R_CTRL, cw(1, 0, 2, 0, 0, 0, 0, 0));
    wr(`THC_R_CMD, 32'h1);
    tick(20);
    chk(s0, 32'(pulses));
    report_and_stop;
  end
endmodule // thc_tb_top
